/* bench/lrb_master.sv */
// bus master model: one-cycle byte writes into the led register bank
// assumes the bank samples wr_stb, wr_addr and wr_data on rising mclk
`timescale 1ns/100ps
`include "lrb_cfg.svh"
module lrb_master
  import lrb_pkg::*;
(
  input  wire logic mclk,
  output logic      wr_stb,
  output lrb_byte_t wr_addr,
  output lrb_byte_t wr_data
);
  initial begin
    wr_stb  = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
  end
  // back-to-back calls keep the strobe up; call idle to release
  task wr(input lrb_byte_t a, input lrb_byte_t d);
    @(negedge mclk);
    wr_stb  = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(posedge mclk);
  endtask : wr
  // released lines show the inverse so stale values never look valid
  task idle;
    @(negedge mclk);
    wr_stb  = 1'b0;
    wr_addr = ~wr_addr;
    wr_data = ~wr_data;
  endtask : idle
  task commit_data;
    wr(`LRB_ADDR_DATA_COMMIT, 8'h00);
  endtask : commit_data
  task commit_time;
    wr(`LRB_ADDR_TIME_COMMIT, 8'h00);
  endtask : commit_time
  task full_reset;
    wr(`LRB_ADDR_FULL_RESET, 8'h00);
  endtask : full_reset
endmodule : lrb_master

/* bench/tb_top.sv */
// self-checking bench for the led register bank
// assumes the master model drives writes on falling mclk edges
`timescale 1ns/100ps
`include "lrb_cfg.svh"
module tb_top
  import lrb_pkg::*;
;
  logic            mclk;
  logic            rst;
  logic            wr_stb;
  lrb_byte_t       wr_addr;
  lrb_byte_t       wr_data;
  logic            run_not_shutdown;
  logic [2:0]      upper_channel_enables;
  logic [2:0]      lower_channel_enables;
  lrb_group_mode_t group_mode_select [2];
  logic [1:0]      group_mode_bits;
  logic            audio_modulation_enable;
  logic            auto_gain_control;
  logic            auto_gain_speed_select;
  lrb_byte_t       current_gain_cfg;
  lrb_byte_t       ramping_cfg;
  lrb_byte_t       breathing_marker_cfg;
  logic [47:0]     duty_cycle;
  logic [47:0]     start_delay;
  logic [15:0]     ramp_hold;
  logic [47:0]     off_time;
  logic            data_commit_pulse;
  logic            timing_commit_pulse;
  logic            full_reset_pulse;
  int              error_cnt;
  int              n_tests;
  lrb_byte_t       e_run, e_en, e_op, e_cg, e_rmp, e_bm;
  logic [47:0]     e_duty, e_sd, e_ot;
  logic [15:0]     e_rh;
  lrb_byte_t       unmapped [11] = '{8'h02, 8'h0d, 8'h0e, 8'h0f, 8'h17, 8'h19, 8'h1c, 8'h23, 8'h25, 8'h27, 8'hfe};

  lrb_master i_lrb_master (.mclk(mclk), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data));
  lrb_reg_bank i_lrb_reg_bank (
    .mclk(mclk), .rst(rst), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
    .run_not_shutdown(run_not_shutdown), .upper_channel_enables(upper_channel_enables),
    .lower_channel_enables(lower_channel_enables), .group_mode_select(group_mode_select),
    .group_mode_bits(group_mode_bits), .audio_modulation_enable(audio_modulation_enable),
    .auto_gain_control(auto_gain_control), .auto_gain_speed_select(auto_gain_speed_select),
    .current_gain_cfg(current_gain_cfg), .ramping_cfg(ramping_cfg), .breathing_marker_cfg(breathing_marker_cfg),
    .duty_cycle(duty_cycle), .start_delay(start_delay), .ramp_hold(ramp_hold), .off_time(off_time),
    .data_commit_pulse(data_commit_pulse), .timing_commit_pulse(timing_commit_pulse),
    .full_reset_pulse(full_reset_pulse));

  always #50 mclk = ~mclk;

  task complete_run;
    $display("compares %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  task chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task chk_p(input logic [2:0] got, input logic [2:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: pulses %h expected %h", $time, got, exp);
    end
  endtask : chk_p
  task pulses(input logic [2:0] exp);
    chk_p({data_commit_pulse, timing_commit_pulse, full_reset_pulse}, exp);
  endtask : pulses
  task defaults;
    {e_run, e_op, e_cg, e_rmp, e_bm} = '0;
    e_en   = 8'h77;
    e_duty = '0;
    e_sd   = '0;
    e_ot   = '0;
    e_rh   = '0;
  endtask : defaults
  task chk_all;
    chk(48'(run_not_shutdown), 48'(e_run[0]));
    chk(48'({upper_channel_enables, lower_channel_enables}), 48'({e_en[6:4], e_en[2:0]}));
    chk(48'(group_mode_bits), 48'(e_op[5:4]));
    chk(48'({group_mode_select[1], group_mode_select[0]}), 48'(e_op[5:4]));
    chk(48'({audio_modulation_enable, auto_gain_control, auto_gain_speed_select}), 48'(e_op[2:0]));
    chk(48'(current_gain_cfg), 48'(e_cg));
    chk(48'(ramping_cfg), 48'(e_rmp));
    chk(48'(breathing_marker_cfg), 48'(e_bm));
    chk(duty_cycle, e_duty);
    chk(start_delay, e_sd);
    chk(48'(ramp_hold), 48'(e_rh));
    chk(off_time, e_ot);
  endtask : chk_all
  task end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  initial begin
    #2000000;
    error_cnt++;
    complete_run;
  end

  initial begin
    mclk      = 1'b0;
    rst       = 1'b1;
    error_cnt = 0;
    n_tests   = 0;
    defaults;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    chk_all;
    pulses(3'b000);
    end_test("reset");
    // reserved bits set while the run bit goes 1 then 0
    i_lrb_master.wr(`LRB_ADDR_SHUTDOWN, 8'hff);
    i_lrb_master.idle;
    e_run = 8'h01;
    chk_all;
    i_lrb_master.wr(`LRB_ADDR_SHUTDOWN, 8'hfe);
    i_lrb_master.idle;
    e_run = 8'h00;
    chk_all;
    end_test("shutdown");
    i_lrb_master.wr(`LRB_ADDR_OPMODE, 8'h15);
    i_lrb_master.wr(`LRB_ADDR_CUR_GAIN, 8'hff);
    i_lrb_master.wr(`LRB_ADDR_RAMPING, 8'hff);
    i_lrb_master.wr(`LRB_ADDR_BREATH_MARK, 8'hff);
    i_lrb_master.idle;
    {e_op, e_cg, e_rmp, e_bm} = {8'h15, 8'hf7, 8'h33, 8'h17};
    chk_all;
    i_lrb_master.wr(`LRB_ADDR_OPMODE, 8'hea);
    i_lrb_master.idle;
    e_op = 8'h22;
    chk_all;
    end_test("config");
    // pending values stay hidden until the commit strobe
    i_lrb_master.wr(`LRB_ADDR_CHAN_EN, 8'hd2);
    for (int ch = 0; ch < 6; ch++)
      i_lrb_master.wr(`LRB_ADDR_DUTY_BASE + 8'(ch), 8'h11 * 8'(ch + 1));
    i_lrb_master.idle;
    chk_all;
    i_lrb_master.commit_data;
    i_lrb_master.idle;
    pulses(3'b100);
    e_en   = 8'h52;
    e_duty = 48'h665544332211;
    chk_all;
    @(negedge mclk);
    pulses(3'b000);
    end_test("data commit");
    i_lrb_master.wr(`LRB_ADDR_CHAN_EN, 8'h00);
    for (int ch = 0; ch < 6; ch++) begin
      i_lrb_master.wr(`LRB_ADDR_T0_BASE + 8'(ch), 8'hff - 8'(ch));
      i_lrb_master.wr(`LRB_ADDR_T4_BASE + 8'(ch), 8'hc0 + 8'(ch));
    end
    i_lrb_master.wr(`LRB_ADDR_T13_BASE, 8'hff);
    i_lrb_master.wr(`LRB_ADDR_T13_BASE + 8'h01, 8'h8f);
    i_lrb_master.idle;
    chk_all;
    i_lrb_master.commit_time;
    i_lrb_master.idle;
    pulses(3'b010);
    e_sd = 48'h3a3b3c3d3e3f;
    e_ot = 48'h050403020100;
    e_rh = 16'h87f7;
    chk_all;
    end_test("timing commit");
    foreach (unmapped[i])
      i_lrb_master.wr(unmapped[i], 8'hff);
    i_lrb_master.idle;
    chk_all;
    pulses(3'b000);
    end_test("unmapped");
    i_lrb_master.full_reset;
    i_lrb_master.idle;
    pulses(3'b001);
    defaults;
    chk_all;
    i_lrb_master.commit_data;
    i_lrb_master.commit_time;
    i_lrb_master.idle;
    chk_all;
    end_test("full reset");
    complete_run;
  end
endmodule : tb_top

/* inc/lrb_cfg.svh */
// register bank constants: byte offsets, field masks, reset values
// assumes byte-wide writes arrive from a bus slave on the same clock
`ifndef LRB_CFG_SVH
`define LRB_CFG_SVH

`define LRB_ADDR_SHUTDOWN      8'h00
`define LRB_ADDR_CHAN_EN       8'h01
`define LRB_ADDR_OPMODE        8'h03
`define LRB_ADDR_CUR_GAIN      8'h04
`define LRB_ADDR_RAMPING       8'h05
`define LRB_ADDR_BREATH_MARK   8'h06
`define LRB_ADDR_DUTY_BASE     8'h07
`define LRB_ADDR_DATA_COMMIT   8'h10
`define LRB_ADDR_T0_BASE       8'h11
`define LRB_ADDR_T13_BASE      8'h1a
`define LRB_ADDR_T4_BASE       8'h1d
`define LRB_ADDR_TIME_COMMIT   8'h26
`define LRB_ADDR_FULL_RESET    8'hff

`define LRB_NUM_CH             6
`define LRB_NUM_GROUPS         2

`define LRB_MASK_SHUTDOWN      8'h01
`define LRB_MASK_CHAN_EN       8'h77
`define LRB_MASK_OPMODE        8'h37
`define LRB_MASK_CUR_GAIN      8'hf7
`define LRB_MASK_RAMPING       8'h33
`define LRB_MASK_BREATH_MARK   8'h17
`define LRB_MASK_DUTY          8'hff
`define LRB_MASK_T0            8'h3f
`define LRB_MASK_T13           8'hf7
`define LRB_MASK_T4            8'h3f

`define LRB_RST_SHUTDOWN       8'h00
`define LRB_RST_CHAN_EN        8'h77
`define LRB_RST_OPMODE         8'h00
`define LRB_RST_CUR_GAIN       8'h00
`define LRB_RST_RAMPING        8'h00
`define LRB_RST_BREATH_MARK    8'h00
`define LRB_RST_DUTY           8'h00
`define LRB_RST_TIME           8'h00

`define LRB_BIT_RUN            0
`define LRB_BIT_GMODE_LO       4
`define LRB_BIT_AUDIO_EN       2
`define LRB_BIT_AGC            1
`define LRB_BIT_AGC_SPEED      0

`endif

/* inc/lrb_pkg.sv */
// types shared by the led register bank files
// assumes lrb_cfg.svh supplies the numeric constants
package lrb_pkg;
  typedef logic [7:0] lrb_byte_t;

  typedef enum logic {
    LRB_DIRECT_DUTY   = 1'b0,
    LRB_ONESHOT_BREATH = 1'b1
  } lrb_group_mode_t;
endpackage : lrb_pkg

/* rtl/lrb_reg_bank.sv */
// write-only register bank of a six-channel led driver
// assumes a bus slave delivers one-cycle byte writes synchronous to mclk
`timescale 1ns/100ps
`include "lrb_cfg.svh"

module lrb_reg_bank
  import lrb_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       wr_stb,
  input  wire lrb_byte_t  wr_addr,
  input  wire lrb_byte_t  wr_data,
  output logic            run_not_shutdown,
  output logic [2:0]      upper_channel_enables,
  output logic [2:0]      lower_channel_enables,
  output lrb_group_mode_t group_mode_select [2],
  output logic [1:0]      group_mode_bits,
  output logic            audio_modulation_enable,
  output logic            auto_gain_control,
  output logic            auto_gain_speed_select,
  output lrb_byte_t       current_gain_cfg,
  output lrb_byte_t       ramping_cfg,
  output lrb_byte_t       breathing_marker_cfg,
  output logic [47:0]     duty_cycle,
  output logic [47:0]     start_delay,
  output logic [15:0]     ramp_hold,
  output logic [47:0]     off_time,
  output logic            data_commit_pulse,
  output logic            timing_commit_pulse,
  output logic            full_reset_pulse
);

  function automatic logic addr_in(input lrb_byte_t a, input lrb_byte_t base, input int n);
    addr_in = (a >= base) && (a < 8'(base + n));
  endfunction : addr_in

  function automatic logic addr_is(input logic stb, input lrb_byte_t a, input lrb_byte_t target);
    addr_is = stb && (a == target);
  endfunction : addr_is

  logic data_commit;
  logic time_commit;
  logic full_clr;

  // strobes decode straight from the write; the byte value is ignored
  assign data_commit = addr_is(wr_stb, wr_addr, `LRB_ADDR_DATA_COMMIT);
  assign time_commit = addr_is(wr_stb, wr_addr, `LRB_ADDR_TIME_COMMIT);
  assign full_clr    = addr_is(wr_stb, wr_addr, `LRB_ADDR_FULL_RESET);

  // direct registers
  lrb_byte_t shutdown_r;
  lrb_byte_t shutdown_nxt;
  lrb_byte_t opmode_r;
  lrb_byte_t opmode_nxt;
  lrb_byte_t cur_gain_r;
  lrb_byte_t cur_gain_nxt;
  lrb_byte_t ramping_r;
  lrb_byte_t ramping_nxt;
  lrb_byte_t bmark_r;
  lrb_byte_t bmark_nxt;
  logic      dcommit_r;
  logic      dcommit_nxt;
  logic      tcommit_r;
  logic      tcommit_nxt;
  logic      fclr_r;
  logic      fclr_nxt;

  always_comb begin
    shutdown_nxt = shutdown_r;
    opmode_nxt   = opmode_r;
    cur_gain_nxt = cur_gain_r;
    ramping_nxt  = ramping_r;
    bmark_nxt    = bmark_r;
    dcommit_nxt  = data_commit;
    tcommit_nxt  = time_commit;
    fclr_nxt     = full_clr;
    if (full_clr) begin
      shutdown_nxt = `LRB_RST_SHUTDOWN;
      opmode_nxt   = `LRB_RST_OPMODE;
      cur_gain_nxt = `LRB_RST_CUR_GAIN;
      ramping_nxt  = `LRB_RST_RAMPING;
      bmark_nxt    = `LRB_RST_BREATH_MARK;
    end else if (wr_stb) begin
      // masks keep reserved positions at zero; other offsets fall through unchanged
      case (wr_addr)
        `LRB_ADDR_SHUTDOWN:    shutdown_nxt = wr_data & `LRB_MASK_SHUTDOWN;
        `LRB_ADDR_OPMODE:      opmode_nxt   = wr_data & `LRB_MASK_OPMODE;
        `LRB_ADDR_CUR_GAIN:    cur_gain_nxt = wr_data & `LRB_MASK_CUR_GAIN;
        `LRB_ADDR_RAMPING:     ramping_nxt  = wr_data & `LRB_MASK_RAMPING;
        `LRB_ADDR_BREATH_MARK: bmark_nxt    = wr_data & `LRB_MASK_BREATH_MARK;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shutdown_r <= `LRB_RST_SHUTDOWN;
      opmode_r   <= `LRB_RST_OPMODE;
      cur_gain_r <= `LRB_RST_CUR_GAIN;
      ramping_r  <= `LRB_RST_RAMPING;
      bmark_r    <= `LRB_RST_BREATH_MARK;
      dcommit_r  <= 1'b0;
      tcommit_r  <= 1'b0;
      fclr_r     <= 1'b0;
    end else begin
      shutdown_r <= shutdown_nxt;
      opmode_r   <= opmode_nxt;
      cur_gain_r <= cur_gain_nxt;
      ramping_r  <= ramping_nxt;
      bmark_r    <= bmark_nxt;
      dcommit_r  <= dcommit_nxt;
      tcommit_r  <= tcommit_nxt;
      fclr_r     <= fclr_nxt;
    end
  end

  // shadowed registers reset to their defaults; the boot pulse reloads the
  // enable default once more so pending and active agree after release
  lrb_byte_t en_pend;
  lrb_byte_t en_act;
  logic      boot_r;
  logic      boot_nxt;

  always_comb begin
    boot_nxt = 1'b0;
  end

  // boot pulse loads the nonzero channel-enable default right after reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      boot_r <= 1'b1;
    end else begin
      boot_r <= boot_nxt;
    end
  end

  lrb_shadow_reg #(.MASK(`LRB_MASK_CHAN_EN), .RST_V(`LRB_RST_CHAN_EN)) u_chan_en (
    .mclk   (mclk),
    .rst    (rst),
    .clear  (full_clr | boot_r),
    .hit    (addr_is(wr_stb, wr_addr, `LRB_ADDR_CHAN_EN) & ~boot_r),
    .wdata  (wr_data),
    .commit (data_commit & ~boot_r),
    .pend_q (en_pend),
    .act_q  (en_act)
  );

  lrb_byte_t duty_pend [`LRB_NUM_CH];
  lrb_byte_t t0_pend   [`LRB_NUM_CH];
  lrb_byte_t t4_pend   [`LRB_NUM_CH];
  lrb_byte_t t13_pend  [`LRB_NUM_GROUPS];

  genvar gi;
  generate
    for (gi = 0; gi < `LRB_NUM_CH; gi++) begin : g_ch
      lrb_shadow_reg #(.MASK(`LRB_MASK_DUTY), .RST_V(`LRB_RST_DUTY)) u_duty (
        .mclk   (mclk),
        .rst    (rst),
        .clear  (full_clr),
        .hit    (addr_is(wr_stb, wr_addr, 8'(`LRB_ADDR_DUTY_BASE + gi))),
        .wdata  (wr_data),
        .commit (data_commit),
        .pend_q (duty_pend[gi]),
        .act_q  (duty_cycle[gi*8 +: 8])
      );
      lrb_shadow_reg #(.MASK(`LRB_MASK_T0), .RST_V(`LRB_RST_TIME)) u_t0 (
        .mclk   (mclk),
        .rst    (rst),
        .clear  (full_clr),
        .hit    (addr_is(wr_stb, wr_addr, 8'(`LRB_ADDR_T0_BASE + gi))),
        .wdata  (wr_data),
        .commit (time_commit),
        .pend_q (t0_pend[gi]),
        .act_q  (start_delay[gi*8 +: 8])
      );
      lrb_shadow_reg #(.MASK(`LRB_MASK_T4), .RST_V(`LRB_RST_TIME)) u_t4 (
        .mclk   (mclk),
        .rst    (rst),
        .clear  (full_clr),
        .hit    (addr_is(wr_stb, wr_addr, 8'(`LRB_ADDR_T4_BASE + gi))),
        .wdata  (wr_data),
        .commit (time_commit),
        .pend_q (t4_pend[gi]),
        .act_q  (off_time[gi*8 +: 8])
      );
    end
    for (gi = 0; gi < `LRB_NUM_GROUPS; gi++) begin : g_grp
      lrb_shadow_reg #(.MASK(`LRB_MASK_T13), .RST_V(`LRB_RST_TIME)) u_t13 (
        .mclk   (mclk),
        .rst    (rst),
        .clear  (full_clr),
        .hit    (addr_is(wr_stb, wr_addr, 8'(`LRB_ADDR_T13_BASE + gi))),
        .wdata  (wr_data),
        .commit (time_commit),
        .pend_q (t13_pend[gi]),
        .act_q  (ramp_hold[gi*8 +: 8])
      );
      // mode bit 0 is direct duty, 1 is one-shot breathing
      assign group_mode_select[gi] = lrb_group_mode_t'(opmode_r[`LRB_BIT_GMODE_LO + gi]);
    end
  endgenerate

  assign run_not_shutdown        = shutdown_r[`LRB_BIT_RUN];
  assign upper_channel_enables   = en_act[6:4];
  assign lower_channel_enables   = en_act[2:0];
  assign group_mode_bits         = opmode_r[5:4];
  assign audio_modulation_enable = opmode_r[`LRB_BIT_AUDIO_EN];
  assign auto_gain_control       = opmode_r[`LRB_BIT_AGC];
  assign auto_gain_speed_select  = opmode_r[`LRB_BIT_AGC_SPEED];
  assign current_gain_cfg        = cur_gain_r;
  assign ramping_cfg             = ramping_r;
  assign breathing_marker_cfg    = bmark_r;
  assign data_commit_pulse       = dcommit_r;
  assign timing_commit_pulse     = tcommit_r;
  assign full_reset_pulse        = fclr_r;

  // checks
  logic unmapped;
  assign unmapped = wr_stb && !(wr_addr <= `LRB_ADDR_CHAN_EN || addr_in(wr_addr, `LRB_ADDR_OPMODE, 10)
                    || addr_in(wr_addr, `LRB_ADDR_T0_BASE, 6) || addr_in(wr_addr, `LRB_ADDR_T13_BASE, 2)
                    || addr_in(wr_addr, `LRB_ADDR_T4_BASE, 6) || wr_addr == `LRB_ADDR_TIME_COMMIT
                    || wr_addr == `LRB_ADDR_FULL_RESET || wr_addr == `LRB_ADDR_DATA_COMMIT);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_data_commit_wr;
    addr_is(wr_stb, wr_addr, `LRB_ADDR_DATA_COMMIT) && !boot_r;
  endsequence
  sequence s_single_pulse;
    data_commit_pulse ##1 (!data_commit_pulse || $past(data_commit));
  endsequence

  a_shutdown_write: assert property (addr_is(wr_stb, wr_addr, `LRB_ADDR_SHUTDOWN) |=>
    run_not_shutdown == $past(wr_data[0]) && shutdown_r[7:1] == 7'h00)
    else $error("shutdown bit not taken from write");
  a_enable_reset: assert property ($fell(boot_r) |-> en_act == 8'h77)
    else $error("channel enables not at default after reset");
  a_enable_hold: assert property (!data_commit && !full_clr && !boot_r |=> $stable(en_act))
    else $error("enables changed without commit");
  a_mode_follow: assert property (addr_is(wr_stb, wr_addr, `LRB_ADDR_OPMODE) |=>
    group_mode_bits == $past(wr_data[5:4]) && group_mode_select[1] == lrb_group_mode_t'($past(wr_data[5])))
    else $error("group mode not taken from write");
  a_duty_commit: assert property (s_data_commit_wr |=> duty_cycle[7:0] == $past(duty_pend[0])
    && en_act == $past(en_pend))
    else $error("duty commit did not load active value");
  a_commit_pulse: assert property (s_data_commit_wr |=> s_single_pulse)
    else $error("commit pulse not one cycle");
  a_time_commit: assert property (time_commit |=> off_time[47:40] == $past(t4_pend[5])
    && start_delay[7:0] == $past(t0_pend[0]) && ramp_hold[15:8] == $past(t13_pend[1]))
    else $error("timing commit did not load active value");
  a_full_reset: assert property (full_clr |=> full_reset_pulse && !run_not_shutdown
    && en_act == 8'h77 && ramping_cfg == 8'h00 && duty_cycle == 48'h0 && off_time == 48'h0)
    else $error("full reset left a register off default");
  a_unmapped_quiet: assert property (unmapped |=> $stable(shutdown_r) && $stable(opmode_r)
    && $stable(cur_gain_r) && $stable(duty_cycle) && $stable(en_act) && $stable(off_time))
    else $error("unassigned write changed state");
endmodule : lrb_reg_bank

/* rtl/lrb_shadow_reg.sv */
// one byte register with pending storage and a committed active copy
// assumes hit, commit and clear are single-cycle strobes on mclk
`timescale 1ns/100ps
module lrb_shadow_reg
  import lrb_pkg::*;
#(
  parameter lrb_byte_t MASK  = 8'hff,
  parameter lrb_byte_t RST_V = 8'h00
) (
  input  wire logic      mclk,
  input  wire logic      rst,
  input  wire logic      clear,
  input  wire logic      hit,
  input  wire lrb_byte_t wdata,
  input  wire logic      commit,
  output lrb_byte_t      pend_q,
  output lrb_byte_t      act_q
);
  lrb_byte_t pend_r;
  lrb_byte_t pend_nxt;
  lrb_byte_t act_r;
  lrb_byte_t act_nxt;

  always_comb begin
    pend_nxt = pend_r;
    act_nxt  = act_r;
    if (clear) begin
      pend_nxt = RST_V;
      act_nxt  = RST_V;
    end else begin
      // reserved bits never reach storage
      if (hit) begin
        pend_nxt = (wdata & MASK) | (RST_V & ~MASK);
      end
      if (commit) begin
        act_nxt = pend_r;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pend_r <= RST_V;
      act_r  <= RST_V;
    end else begin
      pend_r <= pend_nxt;
      act_r  <= act_nxt;
    end
  end

  // clear wins over a write or a commit in the same cycle
  assign pend_q = pend_r;
  assign act_q  = act_r;
endmodule : lrb_shadow_reg
